// ==== logic/upc_regs.svh ====
// Contract
// [RULE_01] host bit selects host or peripheral role
// [RULE_02] pullup needs connect and vbus gate check
// [RULE_03] vbus change flag plus readable status
// [RULE_04] pulldown bits connect; host sets both
// [RULE_05] host attach or detach raises flag
// [RULE_06] chip reset spares pin and bus control
// [RULE_07] master treats fifo data as undefined
// [RULE_08] output inactive while irq enable clear
// [RULE_09] irq enable clear after any reset
// [RULE_10] level mode: open drain low on flag
// [RULE_11] level released after last flag cleared
// [RULE_12] polarity ignored in level mode
// [RULE_13] edge mode push pull, polarity chosen
// [RULE_14] enabled general input flags reach output
// [RULE_15] usb service events reach output
// [RULE_16] system supplies single edge clock
// [RULE_17] comparator usable as general input
// [RULE_18] edge on new request or partial clear
// [RULE_19] polarity one high, zero low
// [RULE_20] pulse length from two select bits
// [RULE_21] pullup gating recomputed every cycle
// [RULE_22] reset pin synchronised before use
`ifndef UPC_REGS_SVH
`define UPC_REGS_SVH

// ----------------------------------------------------------------
// clock and pulse timing
// ----------------------------------------------------------------
`define UPC_CLK_NS          40
`define UPC_PW0_NS          10600
`define UPC_PW1_NS          5300
`define UPC_PW2_NS          2600
`define UPC_PW3_NS          1300
`define UPC_PW0_CYC         (`UPC_PW0_NS / `UPC_CLK_NS)
`define UPC_PW1_CYC         (`UPC_PW1_NS / `UPC_CLK_NS)
`define UPC_PW2_CYC         (`UPC_PW2_NS / `UPC_CLK_NS)
`define UPC_PW3_CYC         (`UPC_PW3_NS / `UPC_CLK_NS)

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define UPC_ADDR_MODE       4'h0
`define UPC_ADDR_BUS_CTL    4'h1
`define UPC_ADDR_CPU_CTL    4'h2
`define UPC_ADDR_PIN_CTL    4'h3
`define UPC_ADDR_USB_FLAG   4'h4
`define UPC_ADDR_USB_EN     4'h5
`define UPC_ADDR_GP_FLAG    4'h6
`define UPC_ADDR_GP_EN      4'h7
`define UPC_ADDR_GP_POL     4'h8
`define UPC_ADDR_STATUS     4'h9
`define UPC_ADDR_GP_IN      4'hA

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define UPC_MODE_HOST       0
`define UPC_MODE_DP_PD      1
`define UPC_MODE_DM_PD      2
`define UPC_BUS_CONNECT     0
`define UPC_BUS_VGATE       1
`define UPC_CPU_IRQ_EN      0
`define UPC_CPU_PW_LO       6
`define UPC_CPU_PW_HI       7
`define UPC_PIN_POL_HI      0
`define UPC_PIN_LVL_SEL     1
`define UPC_USBF_ATTACH     0
`define UPC_USBF_VBUS       1
`define UPC_USBF_EVT_LO     2
`define UPC_STAT_VBUS       0
`define UPC_STAT_ATTACH     1
`define UPC_STAT_PEND       2
`define UPC_STAT_HOST       3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define UPC_RST_REG         8'h00

`endif

// ==== logic/upc_pkg.sv ====
`default_nettype none
package upc_pkg;
    typedef logic [3:0] upc_addr_t;
    typedef logic [7:0] upc_data_t;
    typedef enum logic [2:0] {
        UPC_P_IDLE   = 3'h1,
        UPC_P_ACTIVE = 3'h2,
        UPC_P_GAP    = 3'h4
    } upc_pulse_st_t;
endpackage
`default_nettype wire

// ==== logic/upc_pulse_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface upc_pulse_if;
    logic       trig;
    logic       en;
    logic [1:0] len_sel;
    logic       active;
    modport ctl (output trig, output en, output len_sel, input active);
    modport gen (input trig, input en, input len_sel, output active);
endinterface
`default_nettype wire

// ==== logic/upc_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
module upc_sync #(
    parameter int WIDTH = 11
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;

    // meta_q feeds q only; nothing else may look at it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else if (ce) begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ==== logic/upc_irq_pulse.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "upc_regs.svh"
module upc_irq_pulse (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    upc_pulse_if.gen  pif
);
    upc_pkg::upc_pulse_st_t st_q, st_d;
    logic [8:0]             cnt_q, cnt_d;
    logic [8:0]             len_q;
    logic [8:0]             wcnt_q;
    logic                   pend_q, pend_d;
    logic                   start;

    function automatic logic [8:0] len_cycles(input logic [1:0] sel);
        case (sel)
            2'h0:    len_cycles = 9'(`UPC_PW0_CYC);
            2'h1:    len_cycles = 9'(`UPC_PW1_CYC);
            2'h2:    len_cycles = 9'(`UPC_PW2_CYC);
            default: len_cycles = 9'(`UPC_PW3_CYC);
        endcase
    endfunction

    // ----------------------------------------------------------------
    // pulse sequencer
    // ----------------------------------------------------------------
    // the gap state guarantees a fresh edge for a request queued mid pulse
    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        start = 1'b0;
        case (st_q)
            upc_pkg::UPC_P_IDLE: begin
                if (pif.trig || pend_q) begin
                    st_d  = upc_pkg::UPC_P_ACTIVE;
                    cnt_d = len_cycles(pif.len_sel) - 9'h001; // RULE_20
                    start = 1'b1;
                end
            end
            upc_pkg::UPC_P_ACTIVE: begin
                if (cnt_q == 9'h000) begin
                    st_d = upc_pkg::UPC_P_GAP;
                end else begin
                    cnt_d = cnt_q - 9'h001;
                end
            end
            upc_pkg::UPC_P_GAP: begin
                st_d = upc_pkg::UPC_P_IDLE;
            end
            default: begin
                st_d = upc_pkg::UPC_P_IDLE;
            end
        endcase
        if (!pif.en) begin
            st_d  = upc_pkg::UPC_P_IDLE;
            start = 1'b0;
        end
        pend_d = pif.en & ((pend_q & ~start) | (pif.trig & (st_q != upc_pkg::UPC_P_IDLE))); // RULE_18
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q   <= upc_pkg::UPC_P_IDLE;
            cnt_q  <= 9'h000;
            pend_q <= 1'b0;
        end else if (ce) begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            pend_q <= pend_d;
        end
    end

    assign pif.active = (st_q == upc_pkg::UPC_P_ACTIVE);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            len_q  <= 9'h000;
            wcnt_q <= 9'h000;
        end else if (ce) begin
            if (start) begin
                len_q  <= len_cycles(pif.len_sel);
                wcnt_q <= 9'h000;
            end else if (pif.active) begin
                wcnt_q <= wcnt_q + 9'h001;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || !ce);

    sequence s_idle_req;
        pif.en && pif.trig && (st_q == upc_pkg::UPC_P_IDLE);
    endsequence

    a_pulse_start: assert property (s_idle_req |=> pif.active) // RULE_18
        else $error("pulse did not start on request");
    a_pulse_width: assert property (
        (pif.active && cnt_q == 9'h000 && pif.en) |-> (wcnt_q + 9'h001 == len_q)) // RULE_20
        else $error("pulse length differs from selected width");
    a_pulse_gap: assert property ($fell(pif.active) |=> !pif.active) // RULE_18
        else $error("pulse restarted without a gap");
endmodule
`default_nettype wire

// ==== logic/upc_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "upc_regs.svh"
module upc_top (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                ce,
    input  wire upc_pkg::upc_addr_t  addr,
    input  wire upc_pkg::upc_data_t  wdata,
    input  wire logic                wr_en,
    input  wire logic                rd_en,
    output upc_pkg::upc_data_t       rdata,
    input  wire logic                chip_reset_n,
    input  wire logic                bus_power_comparator_input,
    input  wire logic                attach_sense,
    input  wire logic [7:0]          general_inputs,
    input  wire logic [5:0]          usb_event,
    output logic                     host_mode,
    output logic                     dplus_pullup_enable,
    output logic                     dplus_pulldown_enable,
    output logic                     dminus_pulldown_enable,
    output logic                     irq_out,
    output logic                     irq_oe
);
    // ----------------------------------------------------------------
    // reset release and input synchronisers
    // ----------------------------------------------------------------
    logic [1:0]  rst_pipe_q;
    logic        rst_s_n;
    logic [10:0] sync_q;
    logic        chip_rst;
    logic        bus_power_detected;
    logic        attach_s;
    logic [7:0]  gp_s;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe_q <= 2'h0;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end
    assign rst_s_n = rst_pipe_q[1];

    upc_sync #(
        .WIDTH (11)
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_s_n),
        .ce    (ce),
        .d     ({chip_reset_n, attach_sense, bus_power_comparator_input, general_inputs}),
        .q     (sync_q)
    );

    assign chip_rst           = ~sync_q[10]; // RULE_22
    assign attach_s           = sync_q[9];
    assign bus_power_detected = sync_q[8]; // RULE_17
    assign gp_s               = sync_q[7:0];

    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    function automatic logic wr_hit(input upc_pkg::upc_addr_t a, input logic w,
                                    input upc_pkg::upc_addr_t r);
        wr_hit = w && (a == r);
    endfunction

    function automatic logic [7:0] w1c(input logic [7:0] q, input logic [7:0] set,
                                       input logic [7:0] clr);
        w1c = (q & ~clr) | set;
    endfunction

    upc_pkg::upc_data_t mode_q, bus_ctl_q, cpu_ctl_q, pin_ctl_q;
    upc_pkg::upc_data_t usb_en_q, gp_en_q, gp_pol_q;
    upc_pkg::upc_data_t usb_flag_q, usb_flag_d, gp_flag_q, gp_flag_d;
    logic               host_q, connect_q, vbus_gate_enable, irq_output_enable;
    logic               irq_level_select, irq_polarity_high;
    logic               irq_pulse_len_hi, irq_pulse_len_lo;

    assign host_q            = mode_q[`UPC_MODE_HOST];
    assign connect_q         = bus_ctl_q[`UPC_BUS_CONNECT];
    assign vbus_gate_enable  = bus_ctl_q[`UPC_BUS_VGATE];
    assign irq_output_enable = cpu_ctl_q[`UPC_CPU_IRQ_EN];
    assign irq_pulse_len_hi  = cpu_ctl_q[`UPC_CPU_PW_HI];
    assign irq_pulse_len_lo  = cpu_ctl_q[`UPC_CPU_PW_LO];
    assign irq_level_select  = pin_ctl_q[`UPC_PIN_LVL_SEL];
    assign irq_polarity_high = pin_ctl_q[`UPC_PIN_POL_HI];

    // pin and bus control survive a chip reset, only power-on clears them
    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            bus_ctl_q <= `UPC_RST_REG;
            pin_ctl_q <= `UPC_RST_REG;
        end else if (ce) begin
            if (wr_hit(addr, wr_en, `UPC_ADDR_BUS_CTL)) begin
                bus_ctl_q <= wdata;
            end else if (wr_hit(addr, wr_en, `UPC_ADDR_PIN_CTL)) begin
                pin_ctl_q <= wdata;
            end
        end
    end

    // everything else returns to default while the reset pin is low
    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            mode_q    <= `UPC_RST_REG;
            cpu_ctl_q <= `UPC_RST_REG;
            usb_en_q  <= `UPC_RST_REG;
            gp_en_q   <= `UPC_RST_REG;
            gp_pol_q  <= `UPC_RST_REG;
        end else if (ce) begin
            if (chip_rst) begin
                mode_q    <= `UPC_RST_REG; // RULE_06
                cpu_ctl_q <= `UPC_RST_REG; // RULE_09
                usb_en_q  <= `UPC_RST_REG;
                gp_en_q   <= `UPC_RST_REG;
                gp_pol_q  <= `UPC_RST_REG;
            end else if (wr_hit(addr, wr_en, `UPC_ADDR_MODE)) begin
                mode_q <= wdata; // RULE_01
            end else if (wr_hit(addr, wr_en, `UPC_ADDR_CPU_CTL)) begin
                cpu_ctl_q <= wdata;
            end else if (wr_hit(addr, wr_en, `UPC_ADDR_USB_EN)) begin
                usb_en_q <= wdata;
            end else if (wr_hit(addr, wr_en, `UPC_ADDR_GP_EN)) begin
                gp_en_q <= wdata;
            end else if (wr_hit(addr, wr_en, `UPC_ADDR_GP_POL)) begin
                gp_pol_q <= wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // event flags
    // ----------------------------------------------------------------
    logic       attach_prev_q, vbus_prev_q;
    logic [7:0] gp_prev_q;
    logic [7:0] usb_set, gp_set;
    logic [7:0] usb_clr, gp_clr;

    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            attach_prev_q <= 1'b0;
            vbus_prev_q   <= 1'b0;
            gp_prev_q     <= 8'h00;
        end else if (ce) begin
            attach_prev_q <= attach_s;
            vbus_prev_q   <= bus_power_detected;
            gp_prev_q     <= gp_s;
        end
    end

    assign usb_set[`UPC_USBF_ATTACH] = host_q & (attach_s ^ attach_prev_q); // RULE_05
    assign usb_set[`UPC_USBF_VBUS]   = bus_power_detected ^ vbus_prev_q; // RULE_03
    assign usb_set[7:`UPC_USBF_EVT_LO] = usb_event; // RULE_15

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_gp_edge
            // polarity picks which transition of each input counts
            assign gp_set[gi] = gp_pol_q[gi] ? (gp_s[gi] & ~gp_prev_q[gi])
                                             : (~gp_s[gi] & gp_prev_q[gi]);
        end
    endgenerate

    assign usb_clr    = wr_hit(addr, wr_en, `UPC_ADDR_USB_FLAG) ? wdata : 8'h00;
    assign gp_clr     = wr_hit(addr, wr_en, `UPC_ADDR_GP_FLAG) ? wdata : 8'h00;
    // a set in the same cycle as its clear is kept
    assign usb_flag_d = chip_rst ? `UPC_RST_REG : w1c(usb_flag_q, usb_set, usb_clr);
    assign gp_flag_d  = chip_rst ? `UPC_RST_REG : w1c(gp_flag_q, gp_set, gp_clr); // RULE_14

    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            usb_flag_q <= `UPC_RST_REG;
            gp_flag_q  <= `UPC_RST_REG;
        end else if (ce) begin
            usb_flag_q <= usb_flag_d;
            gp_flag_q  <= gp_flag_d;
        end
    end

    // ----------------------------------------------------------------
    // interrupt output
    // ----------------------------------------------------------------
    logic [15:0] masked_q, masked_d;
    logic        any_pend;
    logic        edge_trig;

    upc_pulse_if pls ();

    assign masked_q  = {usb_flag_q & usb_en_q, gp_flag_q & gp_en_q};
    assign masked_d  = {usb_flag_d & usb_en_q, gp_flag_d & gp_en_q};
    assign any_pend  = |masked_q;
    // a new request, or a partial clear that leaves work pending
    assign edge_trig = (|(masked_d & ~masked_q)) | ((|(masked_q & ~masked_d)) & (|masked_d)); // RULE_18

    assign pls.trig    = edge_trig & ~irq_level_select;
    assign pls.en      = irq_output_enable & ~irq_level_select;
    assign pls.len_sel = {irq_pulse_len_hi, irq_pulse_len_lo}; // RULE_20

    upc_irq_pulse u_pulse (
        .clk   (clk),
        .rst_n (rst_s_n),
        .ce    (ce),
        .pif   (pls)
    );

    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            irq_out <= 1'b1;
            irq_oe  <= 1'b0;
        end else if (ce) begin
            if (irq_level_select) begin
                irq_out <= 1'b0; // RULE_12
                irq_oe  <= irq_output_enable & any_pend; // RULE_10 RULE_11 RULE_08
            end else begin
                irq_oe  <= 1'b1; // RULE_13
                irq_out <= (irq_output_enable & pls.active) ? irq_polarity_high
                                                            : ~irq_polarity_high; // RULE_19 RULE_08
            end
        end
    end

    // ----------------------------------------------------------------
    // pins
    // ----------------------------------------------------------------
    // registered each cycle so a lost bus supply drops the pullup unaided
    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            dplus_pullup_enable <= 1'b0;
        end else if (ce) begin
            dplus_pullup_enable <= ~host_q & connect_q & (~vbus_gate_enable | bus_power_detected); // RULE_02 RULE_21
        end
    end

    assign host_mode              = host_q;
    assign dplus_pulldown_enable  = mode_q[`UPC_MODE_DP_PD]; // RULE_04
    assign dminus_pulldown_enable = mode_q[`UPC_MODE_DM_PD]; // RULE_04

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    upc_pkg::upc_data_t rd_mux;
    upc_pkg::upc_data_t status;

    assign status = {4'h0, host_q, any_pend, attach_s, bus_power_detected}; // RULE_03 RULE_17

    always_comb begin
        if (addr == `UPC_ADDR_MODE) begin
            rd_mux = mode_q;
        end else if (addr == `UPC_ADDR_BUS_CTL) begin
            rd_mux = bus_ctl_q;
        end else if (addr == `UPC_ADDR_CPU_CTL) begin
            rd_mux = cpu_ctl_q;
        end else if (addr == `UPC_ADDR_PIN_CTL) begin
            rd_mux = pin_ctl_q;
        end else if (addr == `UPC_ADDR_USB_FLAG) begin
            rd_mux = usb_flag_q;
        end else if (addr == `UPC_ADDR_USB_EN) begin
            rd_mux = usb_en_q;
        end else if (addr == `UPC_ADDR_GP_FLAG) begin
            rd_mux = gp_flag_q;
        end else if (addr == `UPC_ADDR_GP_EN) begin
            rd_mux = gp_en_q;
        end else if (addr == `UPC_ADDR_GP_POL) begin
            rd_mux = gp_pol_q;
        end else if (addr == `UPC_ADDR_STATUS) begin
            rd_mux = status;
        end else if (addr == `UPC_ADDR_GP_IN) begin
            rd_mux = gp_s;
        end else begin
            rd_mux = 8'h00;
        end
    end

    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            rdata <= 8'h00;
        end else if (ce) begin
            rdata <= rd_en ? rd_mux : 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_s_n || !ce);

    sequence s_partial_clear;
        irq_level_select && irq_output_enable && !chip_rst &&
        wr_hit(addr, wr_en, `UPC_ADDR_USB_FLAG) && ((usb_flag_q & usb_en_q & ~wdata) != 8'h00);
    endsequence

    a_pullup_gated: assert property (
        (!host_q && connect_q && vbus_gate_enable && !bus_power_detected) |=> !dplus_pullup_enable) // RULE_02
        else $error("pullup connected without bus power");
    a_pullup_follow: assert property (
        ($fell(bus_power_detected) && vbus_gate_enable && $stable(bus_ctl_q)) |-> ##1 !dplus_pullup_enable) // RULE_21
        else $error("pullup did not drop with bus power");
    // the sampled reset term skips the edge at which the output flops leave reset
    a_irq_off_inactive: assert property (
        (rst_s_n && !irq_output_enable && !wr_hit(addr, wr_en, `UPC_ADDR_PIN_CTL)) |=>
        (irq_level_select ? !irq_oe : (irq_oe && irq_out == !irq_polarity_high))) // RULE_08
        else $error("interrupt pin active while disabled");
    a_level_drive: assert property (
        (irq_level_select && irq_output_enable && any_pend) |=> (irq_oe && !irq_out)) // RULE_10
        else $error("level mode pin not pulled low");
    a_level_hold: assert property (s_partial_clear |=> ##1 irq_oe) // RULE_11
        else $error("level pin released with requests pending");
    a_edge_polarity: assert property (
        (!irq_level_select && irq_output_enable && pls.active) |=> (irq_out == $past(irq_polarity_high))) // RULE_19
        else $error("edge pulse has wrong polarity");
    a_attach_flag: assert property (
        (host_q && (attach_s != attach_prev_q) && !chip_rst) |=> usb_flag_q[`UPC_USBF_ATTACH]) // RULE_05
        else $error("attach change not flagged");
    a_chip_reset: assert property (
        (chip_rst && !wr_en) |=> (!irq_output_enable && mode_q == 8'h00 && $stable(pin_ctl_q))) // RULE_06
        else $error("chip reset cleared wrong registers");
endmodule
`default_nettype wire

// ==== bench/upc_irq_host.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----
// interrupt line as the servicing master sees it
// ----
module upc_irq_host (
    input  wire logic irq_out,
    input  wire logic irq_oe,
    output wire logic irq_pin
);
    // a released line rises through the external pull-up
    assign irq_pin = irq_oe ? irq_out : 1'b1;
endmodule
`default_nettype wire

// ==== bench/tb_usb_pin_control_and_irq_output.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_usb_pin_control_and_irq_output;
    logic               clk, rst_n, wr_en, rd_en, crst_n, vbus, att, ce;
    upc_pkg::upc_addr_t addr;
    upc_pkg::upc_data_t wdata, rdata;
    logic [7:0]         gin;
    logic [5:0]         evt;
    logic               host, pu, dp, dm, irq_out, irq_oe;
    wire                irq_pin;
    int                 error_cnt, cmp_count, n;
    int                 pw [4] = '{265, 132, 65, 32};
    // row: mode, bus ctl, comparator, expected {host, pullup, d+ pd, d- pd}
    logic [15:0]        rows [6] = '{16'h0000, 16'h0104, 16'h0300, 16'h0314, 16'h0300, 16'h711B};
    upc_top dut (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .chip_reset_n(crst_n),
        .bus_power_comparator_input(vbus), .attach_sense(att), .general_inputs(gin),
        .usb_event(evt), .host_mode(host), .dplus_pullup_enable(pu),
        .dplus_pulldown_enable(dp), .dminus_pulldown_enable(dm), .irq_out(irq_out), .irq_oe(irq_oe));
    upc_irq_host host_side (.irq_out(irq_out), .irq_oe(irq_oe), .irq_pin(irq_pin));
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wr(input upc_pkg::upc_addr_t a, input upc_pkg::upc_data_t d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input upc_pkg::upc_addr_t a, input upc_pkg::upc_data_t e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk("rdata", 16'(e), 16'(rdata));
    endtask
    task automatic fire;
        @(posedge clk);
        evt <= 6'h01;
        @(posedge clk);
        evt <= 6'h00;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #100000;
        error_cnt++;
        give_verdict();
    end
    initial begin
        {rst_n, wr_en, rd_en, vbus, att, addr, wdata, gin, evt} = '0;
        crst_n = 1'b1;
        ce = 1'b1;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        cyc(8);
        chk("rst", 16'h0003, 16'({host, pu, dp, dm, irq_out, irq_oe}));
        foreach (rows[i]) begin
            wr(4'h0, {4'h0, rows[i][15:12]});
            wr(4'h1, {4'h0, rows[i][11:8]});
            vbus <= rows[i][4];
            cyc(6);
            chk("pins", 16'(rows[i][3:0]), 16'({host, pu, dp, dm}));
        end
        // level mode with polarity set, which must not matter
        wr(4'h4, 8'hFF);
        wr(4'h5, 8'h05);
        wr(4'h3, 8'h03);
        wr(4'h2, 8'h01);
        att <= 1'b1;
        fire();
        cyc(6);
        chk("lvl", 16'h0000, 16'(irq_pin));
        rd(4'h4, 8'h05);
        wr(4'h4, 8'h01);
        cyc(3);
        chk("lvl", 16'h0000, 16'(irq_pin));
        wr(4'h4, 8'h04);
        cyc(3);
        chk("lvl", 16'h0001, 16'(irq_pin));
        wr(4'h8, 8'h01);
        wr(4'h7, 8'h01);
        gin <= 8'h01;
        cyc(6);
        chk("gp", 16'h0000, 16'(irq_pin));
        wr(4'h6, 8'h01);
        cyc(3);
        chk("gp", 16'h0001, 16'(irq_pin));
        // odd passes pulse high, even passes pulse low
        for (int s = 0; s < 4; s++) begin
            wr(4'h3, {7'h00, s[0]});
            wr(4'h4, 8'hFF);
            wr(4'h2, {s[1:0], 6'h01});
            fire();
            for (int i = 0; i < 10 && irq_out !== s[0]; i++) cyc(1);
            n = 0;
            while (irq_out === s[0] && n < 400) begin
                cyc(1);
                n++;
            end
            chk("pulse", 16'(pw[s]), 16'(n));
            cyc(4);
        end
        wr(4'h4, 8'hFF);
        wr(4'h2, 8'h00);
        fire();
        cyc(5);
        chk("idle", 16'h0001, 16'({irq_out, irq_oe}));
        crst_n <= 1'b0;
        cyc(6);
        crst_n <= 1'b1;
        cyc(5);
        rd(4'h0, 8'h00);
        rd(4'h1, 8'h01);
        rd(4'h3, 8'h01);
        rd(4'h2, 8'h00);
        rd(4'h9, 8'h03);
        rd(4'hF, 8'h00);
        // an event that lands while the clock enable is low must be lost
        ce <= 1'b0;
        fire();
        ce <= 1'b1;
        rd(4'h4, 8'h00);
        give_verdict();
    end
endmodule
`default_nettype wire
